// ### nsp_map.svh
/*
  Constants of the NVM page sequencer: register offsets, field positions,
  command codes, key, sizes and timing counts.
  Assumes a 125 MHz system clock and a 4 KB Flash in 256-byte blocks.
*/
`ifndef NSP_MAP_SVH
`define NSP_MAP_SVH
`define NSP_OFF_CTRL_A     12'h000
`define NSP_OFF_CTRL_B     12'h004
`define NSP_OFF_STATUS     12'h008
`define NSP_OFF_KEY        12'h00c
`define NSP_OFF_FUSES      12'h010
`define NSP_CMD_NONE       3'h0
`define NSP_CMD_WRITE      3'h1
`define NSP_CMD_ERASE      3'h2
`define NSP_CMD_ERASE_WR   3'h3
`define NSP_CMD_CLEAR      3'h4
`define NSP_KEY_SPM        8'h9d
`define NSP_KEY_WINDOW     3'h4
`define NSP_BIT_GUARD      0
`define NSP_BIT_LOCK       1
`define NSP_BIT_FLASH_BUSY_FLAG      0
`define NSP_BIT_EEPROM_BUSY_FLAG     1
`define NSP_BIT_WRERR      2
`define NSP_BLOCK_BYTES    256
`define NSP_FLASH_BLOCKS   8'h10
`define NSP_BOOT_DEFAULT   8'h00
`define NSP_CODE_DEFAULT   8'h00
`define NSP_PAGE_BYTES     64
`define NSP_LAST_INDEX     6'h3f
`define NSP_CLEAR_CYCLES   3'h7
`define NSP_RESP_OKAY      2'h0
`define NSP_RESP_SLVERR    2'h2
`endif

// ### nsp_pkg.sv
/*
  Types shared by the NVM page sequencer.
  Assumes nothing beyond the constants header.
*/
package nsp_pkg;
  typedef enum {ST_IDLE, ST_ERASE, ST_WRITE, ST_CLEAR} nsp_state_t;
  typedef enum logic [1:0] {MEM_FLASH, MEM_EEPROM, MEM_USER} nsp_mem_t;
  typedef enum logic [1:0] {RGN_BOOT, RGN_CODE, RGN_DATA} nsp_region_t;
endpackage

// ### nsp_sequencer.sv
/*
  NVM page sequencer: Flash region map from end fuses, write protection,
  shared AND-merge page buffer, key-unlocked commands, array sequencing.
  Assumes an AXI4-Lite master for registers, a CPU store/load port, and
  an array port that acknowledges each request with a one-cycle ack.
*/
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`include "nsp_map.svh"

module nsp_sequencer
  import nsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic [7:0]  bootEndFuse,
  input  wire logic [7:0]  codeEndFuse,
  input  wire logic [11:0] cpuPc,
  input  wire logic        instrRetire,
  input  wire logic        wakeUp,
  input  wire logic        storeValid,
  input  wire logic [1:0]  storeMem,
  input  wire logic [11:0] storeAddr,
  input  wire logic [7:0]  storeData,
  input  wire logic        storeDebug,
  input  wire logic        loadValid,
  input  wire logic [11:0] loadAddr,
  output logic             loadWait,
  output logic             loadDenied,
  output logic             cpuHalt,
  output logic             arrayReq,
  output logic             arrayErase,
  output logic             arrayWhole,
  output logic [1:0]       arrayMem,
  output logic [11:0]      arrayAddr,
  output logic [7:0]       arrayData,
  input  wire logic        arrayAck,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  logic [7:0]  boot_section_end_q;
  logic [7:0]  codeEnd_q;
  logic        awHave_q;
  logic        wHave_q;
  logic [11:0] awAddr_q;
  logic [7:0]  wData_q;
  logic        wLow_q;
  logic        guard_q;
  logic        lock_q;
  logic        keyOpen_q;
  logic [2:0]  keyCount_q;
  logic [2:0]  cmd_q;
  logic        flashBusy_q;
  logic        eeprom_busy_flag_q;
  logic        wrError_q;
  nsp_state_t  state_q;
  logic [5:0]  idx_q;
  logic        eraseThenWrite_q;
  logic        wholeDone_q;
  logic [2:0]  clearCount_q;
  logic [5:0]  page_q;
  nsp_mem_t    mem_q;
  logic        dbg_q;
  logic [7:0]  pageBuf_q [`NSP_PAGE_BYTES];
  logic [`NSP_PAGE_BYTES-1:0] mark_q;

  logic        doWrite;
  logic        cmdWrite;
  logic        cmdAccept;
  logic        cmdAllowed;
  logic        busyAny;
  logic        clearBuf;
  logic        storeTake;
  logic        opEnd;
  logic        stepLast;
  nsp_region_t execRegion;

  // Fuse value past Flash end falls back to its default
  function automatic logic [7:0] fuseClamp(input logic [7:0] f, input logic [7:0] dflt);
    fuseClamp = (f > `NSP_FLASH_BLOCKS) ? dflt : f;
  endfunction

  // Region of a Flash address from the two end values
  function automatic nsp_region_t regionOf(input logic [11:0] a);
    logic [7:0] blk;
    blk = {4'h0, a[11:8]};
    if (boot_section_end_q == 8'h00 || blk < boot_section_end_q)
      regionOf = RGN_BOOT;
    else if (codeEnd_q == 8'h00)
      regionOf = RGN_CODE;
    else if (codeEnd_q <= boot_section_end_q)
      regionOf = RGN_DATA;
    else if (blk < codeEnd_q)
      regionOf = RGN_CODE;
    else
      regionOf = RGN_DATA;
  endfunction

  // Register decode, shared by write and read paths
  function automatic logic [2:0] regSel(input logic [11:0] a);
    case (a)
      `NSP_OFF_CTRL_A: regSel = 3'h1;
      `NSP_OFF_CTRL_B: regSel = 3'h2;
      `NSP_OFF_STATUS: regSel = 3'h3;
      `NSP_OFF_KEY:    regSel = 3'h4;
      `NSP_OFF_FUSES:  regSel = 3'h5;
      default:         regSel = 3'h0;
    endcase
  endfunction

  // Directional write check for the pending page
  always_comb
  begin
    execRegion = regionOf(cpuPc);
    if (mem_q == MEM_FLASH)
    begin
      case (execRegion)
        RGN_BOOT: cmdAllowed = regionOf({page_q, 6'h00}) != RGN_BOOT;
        RGN_CODE: cmdAllowed = regionOf({page_q, 6'h00}) == RGN_DATA;
        default:  cmdAllowed = 1'b0;
      endcase
      if (guard_q && regionOf({page_q, 6'h00}) == RGN_CODE)
        cmdAllowed = 1'b0;
    end
    else if (mem_q == MEM_USER && dbg_q)
      cmdAllowed = 1'b1;
    else
      cmdAllowed = execRegion != RGN_DATA;
  end

  // Command and sequencing strobes
  assign busyAny   = flashBusy_q | eeprom_busy_flag_q;
  assign doWrite   = awHave_q & wHave_q & ~s_axi_bvalid;
  assign cmdWrite  = doWrite & wLow_q & (regSel(awAddr_q) == 3'h1);
  assign cmdAccept = cmdWrite & keyOpen_q & ~busyAny & (state_q == ST_IDLE);
  assign stepLast  = wholeDone_q | (idx_q == `NSP_LAST_INDEX);
  assign opEnd     = ((state_q == ST_WRITE) | ((state_q == ST_ERASE) & ~eraseThenWrite_q))
                     & ((arrayReq & arrayAck & stepLast)
                     | (~arrayReq & stepLast & ~mark_q[idx_q] & (mem_q != MEM_FLASH)));
  assign clearBuf  = reset | wakeUp
                     | (clkEn & (opEnd | ((state_q == ST_CLEAR) & (clearCount_q == 3'h0))));
  assign storeTake = storeValid & ~busyAny & (state_q == ST_IDLE);

  // Fuse capture while reset is held
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      boot_section_end_q <= fuseClamp(bootEndFuse, `NSP_BOOT_DEFAULT);
      codeEnd_q <= fuseClamp(codeEndFuse, `NSP_CODE_DEFAULT);
    end
  end

  // AXI4-Lite write channels and response
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q <= 8'h00;
      wLow_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NSP_RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_q <= s_axi_awaddr;
        awHave_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_q <= s_axi_wdata[7:0];
        wLow_q <= s_axi_wstrb[0];
        wHave_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (regSel(awAddr_q) == 3'h0) ? `NSP_RESP_SLVERR : `NSP_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `NSP_RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `NSP_RESP_OKAY;
        case (regSel(s_axi_araddr))
          3'h1: s_axi_rdata <= {29'h0, cmd_q};
          3'h2: s_axi_rdata <= {30'h0, lock_q, guard_q};
          3'h3: s_axi_rdata <= {29'h0, wrError_q, eeprom_busy_flag_q, flashBusy_q};
          3'h4: s_axi_rdata <= {30'h0, keyOpen_q, 1'b0};
          3'h5: s_axi_rdata <= {16'h0, codeEnd_q, boot_section_end_q};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `NSP_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Protection bits; lock only settable from boot code
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      guard_q <= 1'b0;
      lock_q <= 1'b0;
    end
    else if (clkEn && doWrite && wLow_q && regSel(awAddr_q) == 3'h2)
    begin
      guard_q <= wData_q[`NSP_BIT_GUARD];
      if (execRegion == RGN_BOOT && wData_q[`NSP_BIT_LOCK])
        lock_q <= 1'b1;
    end
  end

  // Load gating: stall while busy, deny boot reads outside boot
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      loadWait <= 1'b0;
      loadDenied <= 1'b0;
    end
    else if (clkEn)
    begin
      loadWait <= loadValid & busyAny;
      loadDenied <= loadValid & lock_q & (execRegion != RGN_BOOT)
                    & (regionOf(loadAddr) == RGN_BOOT);
    end
  end

  // Key window counted in retired instructions
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      keyOpen_q <= 1'b0;
      keyCount_q <= 3'h0;
    end
    else if (clkEn)
    begin
      if (doWrite && wLow_q && regSel(awAddr_q) == 3'h4 && wData_q == `NSP_KEY_SPM)
      begin
        keyOpen_q <= 1'b1;
        keyCount_q <= 3'h0;
      end
      else if (cmdWrite)
        keyOpen_q <= 1'b0;
      else if (keyOpen_q && instrRetire)
      begin
        keyCount_q <= keyCount_q + 3'h1;
        if (keyCount_q + 3'h1 == `NSP_KEY_WINDOW)
          keyOpen_q <= 1'b0;
      end
    end
  end

  // Buffer owner: page, memory and source of the last store
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      page_q <= 6'h00;
      mem_q <= MEM_FLASH;
      dbg_q <= 1'b0;
    end
    else if (clkEn && storeTake)
    begin
      page_q <= storeAddr[11:6];
      mem_q <= nsp_mem_t'(storeMem);
      dbg_q <= storeDebug;
    end
  end

  // Page buffer bytes: AND merge on store, all ones on clear
  genvar g;
  generate
    for (g = 0; g < `NSP_PAGE_BYTES; g++)
    begin : gByte
      always_ff @(posedge clk)
      begin
        if (clearBuf && !(clkEn && storeTake && storeAddr[5:0] == 6'(g) && !reset))
        begin
          pageBuf_q[g] <= 8'hff;
          mark_q[g] <= 1'b0;
        end
        else if (clkEn && storeTake && storeAddr[5:0] == 6'(g))
        begin
          // A store meeting a wake clear merges into an all-ones byte; under reset the store is dropped
          pageBuf_q[g] <= (clearBuf ? 8'hff : pageBuf_q[g]) & storeData;
          mark_q[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // Command acceptance, array sequencing and busy/halt flags
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      cmd_q <= `NSP_CMD_NONE;
      flashBusy_q <= 1'b0;
      eeprom_busy_flag_q <= 1'b0;
      wrError_q <= 1'b0;
      cpuHalt <= 1'b0;
      idx_q <= 6'h00;
      eraseThenWrite_q <= 1'b0;
      wholeDone_q <= 1'b0;
      clearCount_q <= 3'h0;
      arrayReq <= 1'b0;
      arrayErase <= 1'b0;
      arrayWhole <= 1'b0;
      arrayMem <= 2'h0;
      arrayAddr <= 12'h000;
      arrayData <= 8'h00;
    end
    else if (clkEn)
    begin
      if (doWrite && wLow_q && regSel(awAddr_q) == 3'h3 && wData_q[`NSP_BIT_WRERR])
        wrError_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          idx_q <= 6'h00;
          wholeDone_q <= 1'b0;
          if (cmdAccept)
          begin
            cmd_q <= wData_q[2:0];
            case (wData_q[2:0])
              `NSP_CMD_WRITE, `NSP_CMD_ERASE, `NSP_CMD_ERASE_WR:
              begin
                if (!cmdAllowed || (wData_q[2:0] != `NSP_CMD_WRITE && mark_q == '0))
                begin
                  wrError_q <= 1'b1;
                  cmd_q <= `NSP_CMD_NONE;
                end
                else
                begin
                  state_q <= (wData_q[2:0] == `NSP_CMD_WRITE) ? ST_WRITE : ST_ERASE;
                  eraseThenWrite_q <= wData_q[2:0] == `NSP_CMD_ERASE_WR;
                  flashBusy_q <= mem_q == MEM_FLASH;
                  eeprom_busy_flag_q <= mem_q != MEM_FLASH;
                  cpuHalt <= mem_q == MEM_FLASH;
                end
              end
              `NSP_CMD_CLEAR:
              begin
                state_q <= ST_CLEAR;
                clearCount_q <= `NSP_CLEAR_CYCLES - 3'h1;
                cpuHalt <= 1'b1;
              end
              default: cmd_q <= `NSP_CMD_NONE;
            endcase
          end
        end
        ST_CLEAR:
        begin
          clearCount_q <= clearCount_q - 3'h1;
          if (clearCount_q == 3'h0)
          begin
            state_q <= ST_IDLE;
            cpuHalt <= 1'b0;
            cmd_q <= `NSP_CMD_NONE;
          end
        end
        ST_ERASE, ST_WRITE:
        begin
          if (!arrayReq)
          begin
            if (state_q == ST_ERASE && mem_q == MEM_FLASH)
            begin
              arrayReq <= 1'b1;
              arrayWhole <= 1'b1;
              arrayErase <= 1'b1;
              wholeDone_q <= 1'b1;
            end
            else if (mark_q[idx_q] || mem_q == MEM_FLASH)
            begin
              arrayReq <= 1'b1;
              arrayWhole <= 1'b0;
              arrayErase <= state_q == ST_ERASE;
            end
            else if (stepLast)
              idx_q <= 6'h00;
            else
              idx_q <= idx_q + 6'h01;
            arrayMem <= mem_q;
            arrayAddr <= {page_q, (state_q == ST_ERASE && mem_q == MEM_FLASH)
                          ? 6'h00 : idx_q};
            arrayData <= pageBuf_q[idx_q];
          end
          else if (arrayAck)
          begin
            arrayReq <= 1'b0;
            idx_q <= stepLast ? 6'h00 : idx_q + 6'h01;
          end
          if (!arrayReq && stepLast && !mark_q[idx_q] && mem_q != MEM_FLASH
              || arrayReq && arrayAck && stepLast)
          begin
            wholeDone_q <= 1'b0;
            if (state_q == ST_ERASE && eraseThenWrite_q)
              state_q <= ST_WRITE;
            else
            begin
              state_q <= ST_IDLE;
              flashBusy_q <= 1'b0;
              eeprom_busy_flag_q <= 1'b0;
              cpuHalt <= 1'b0;
              cmd_q <= `NSP_CMD_NONE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

// ### nsp_sequencer_props.sv
/*
  Checker for the NVM page sequencer: array handshake, halts, load stalls.
  Assumes it is bound to nsp_sequencer and sees only its ports.
*/
module nsp_sequencer_props
  import nsp_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        loadValid,
  input wire logic        loadWait,
  input wire logic        cpuHalt,
  input wire logic        arrayReq,
  input wire logic        arrayErase,
  input wire logic        arrayWhole,
  input wire logic [1:0]  arrayMem,
  input wire logic [11:0] arrayAddr,
  input wire logic [7:0]  arrayData,
  input wire logic        arrayAck
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Clear command: halt rises with no array request behind it
  sequence s_clear_start;
    $rose(cpuHalt) ##1 !arrayReq;
  endsequence
  sequence s_clear_run;
    cpuHalt [*6] ##1 !cpuHalt;
  endsequence

  // Handshake and halt relations
  property p_req_hold;
    arrayReq && !arrayAck |=> arrayReq && $stable({arrayErase, arrayMem, arrayAddr, arrayData});
  endproperty
  property p_req_gap;
    arrayAck |=> !arrayReq;
  endproperty
  property p_load_wait;
    arrayReq && loadValid |=> loadWait;
  endproperty
  property p_load_free;
    !loadValid |=> !loadWait;
  endproperty
  property p_flash_halt;
    arrayReq && arrayMem == MEM_FLASH |-> cpuHalt;
  endproperty
  property p_eeprom_run;
    arrayReq && arrayMem != MEM_FLASH |-> !cpuHalt && !arrayWhole;
  endproperty
  property p_whole_page;
    arrayReq && arrayWhole |-> arrayErase && arrayMem == MEM_FLASH && arrayAddr[5:0] == 6'h00;
  endproperty
  property p_clear_halt;
    s_clear_start |-> s_clear_run;
  endproperty

  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  a_req_gap: assert property (p_req_gap) else $error("request right after ack");
  a_load_wait: assert property (p_load_wait) else $error("load not stalled");
  a_load_free: assert property (p_load_free) else $error("stall without load");
  a_flash_halt: assert property (p_flash_halt) else $error("flash op without halt");
  a_eeprom_run: assert property (p_eeprom_run) else $error("eeprom op halted");
  a_whole_page: assert property (p_whole_page) else $error("bad whole erase");
  a_clear_halt: assert property (p_clear_halt) else $error("clear halt length");
endmodule

bind nsp_sequencer nsp_sequencer_props chk_u (.*);

// ### nsp_array_model.sv
/*
  Behavioural model of the memory arrays behind the sequencer.
  Assumes each request is held until ack; slow lengthens the answer.
*/
module nsp_array_model
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        arrayReq,
  input  wire logic        arrayErase,
  input  wire logic [11:0] arrayAddr,
  input  wire logic [7:0]  arrayData,
  output logic             arrayAck,
  output logic [7:0]       reqCount,
  output logic [7:0]       eraseCount,
  output logic [15:0]      dataSum,
  output logic [11:0]      lastAddr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] waitQ;

  // One ack pulse per request, then log what was done
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      arrayAck   <= 1'h0;
      waitQ      <= 3'h0;
      reqCount   <= 8'h00;
      eraseCount <= 8'h00;
      dataSum    <= 16'h0000;
      lastAddr   <= 12'h000;
    end
    else if (arrayAck)
      arrayAck <= 1'h0;
    else if (arrayReq && waitQ == (slow ? 3'h4 : 3'h0))
    begin
      arrayAck   <= 1'h1;
      waitQ      <= 3'h0;
      reqCount   <= reqCount + 8'h01;
      eraseCount <= eraseCount + {7'h00, arrayErase};
      dataSum    <= dataSum + (arrayErase ? 16'h0000 : {8'h00, arrayData});
      lastAddr   <= arrayAddr;
    end
    else if (arrayReq)
      waitQ <= waitQ + 3'h1;
  end
endmodule

// ### nsp_testbench.sv
/*
  Self-checking bench for the NVM page sequencer.
  Assumes the array model on the far side and AXI4-Lite register access.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, reset = 1'h1, clkEn = 1'h1, instrRetire = 1'h0, wakeUp = 1'h0;
  logic storeValid = 1'h0, storeDebug = 1'h0, loadValid = 1'h0, slow = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [1:0] storeMem = 2'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [7:0] bootEndFuse = 8'h00, codeEndFuse = 8'h00, storeData = 8'h00;
  logic [11:0] cpuPc = 12'h000, storeAddr = 12'h000, loadAddr = 12'h000;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic loadWait, loadDenied, cpuHalt, arrayReq, arrayErase, arrayWhole, arrayAck;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] arrayMem, s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] arrayData, reqCount, eraseCount, n0, e0;
  logic [11:0] arrayAddr, lastAddr;
  logic [15:0] dataSum, s0;
  logic [31:0] s_axi_rdata, rdv;
  int badCount = 0, samplesChecked = 0;

  nsp_sequencer dut_u (.*);
  nsp_array_model model_u (.*);

  // Free-running system clock
  initial forever #4 clk = ~clk;

  // Verdict and run end
  task automatic printVerdict;
    $display("checks %0d errors %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Cut a hung run short
  initial
  begin
    repeat (50000) @(posedge clk);
    badCount++;
    printVerdict();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rst(input logic [7:0] b, input logic [7:0] c);
    @(posedge clk);
    reset <= 1'h1;
    bootEndFuse <= b;
    codeEndFuse <= c;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, r);
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask

  task automatic idle;
    do rd(12'h008); while (rdv[1:0] !== 2'h0);
  endtask

  task automatic cmd(input logic [2:0] c);
    idle();
    wr(12'h00c, 32'h9d, 2'h0);
    wr(12'h000, {29'h0, c}, 2'h0);
  endtask

  task automatic st(input logic [1:0] m, input logic [11:0] a, input logic [7:0] d,
                    input logic g);
    @(posedge clk);
    storeValid <= 1'h1;
    storeMem <= m;
    storeAddr <= a;
    storeData <= d;
    storeDebug <= g;
    @(posedge clk);
    storeValid <= 1'h0;
  endtask

  task automatic snap;
    n0 = reqCount;
    e0 = eraseCount;
    s0 = dataSum;
  endtask

  task automatic delta(input logic [7:0] dn, input logic [7:0] de, input logic [15:0] ds);
    chk(reqCount - n0, dn);
    chk(eraseCount - e0, de);
    chk(dataSum - s0, ds);
  endtask

  // Write error seen, then cleared by writing one
  task automatic err;
    rd(12'h008);
    chk(rdv[2:0], 32'h4);
    wr(12'h008, 32'h4, 2'h0);
  endtask

  // Fuse map read back, then a write from a region that may not write
  task automatic t_rej(input logic [7:0] b, input logic [7:0] c, input logic [15:0] f,
                       input logic [11:0] pc, input logic [1:0] m, input logic [11:0] a);
    rst(b, c);
    rd(12'h010);
    chk(rdv, {16'h0, f});
    cpuPc <= pc;
    st(m, a, 8'h00, 1'h0);
    snap();
    cmd(3'h1);
    err();
    delta(8'h00, 8'h00, 16'h0);
  endtask

  // EEPROM writes of marked, merged bytes; buffer clean afterwards
  task automatic t_ee;
    rst(8'h04, 8'h08);
    cpuPc <= 12'h100;
    st(2'h1, 12'h045, 8'hf0, 1'h0);
    st(2'h1, 12'h045, 8'h3c, 1'h0);
    st(2'h1, 12'h049, 8'h5a, 1'h0);
    snap();
    cmd(3'h1);
    idle();
    delta(8'h02, 8'h00, 16'h008a);
    chk(lastAddr, 12'h049);
    st(2'h1, 12'h045, 8'hff, 1'h0);
    snap();
    cmd(3'h1);
    idle();
    delta(8'h01, 8'h00, 16'h00ff);
  endtask

  // Dirty the buffer, wipe it by wake or clear command, then refill
  task automatic t_refill(input logic w, input logic [7:0] d);
    st(2'h1, 12'h045, 8'h00, 1'h0);
    if (w)
    begin
      @(posedge clk);
      wakeUp <= 1'h1;
      @(posedge clk);
      wakeUp <= 1'h0;
    end
    else
    begin
      cmd(3'h4);
      while (cpuHalt !== 1'h0) @(posedge clk);
    end
    st(2'h1, 12'h045, d, 1'h0);
    snap();
    cmd(3'h1);
    idle();
    delta(8'h01, 8'h00, {8'h00, d});
  endtask

  // Flash: guard, page write, erase with and without a marked byte
  task automatic t_flash;
    st(2'h0, 12'h440, 8'h00, 1'h0);
    wr(12'h004, 32'h1, 2'h0);
    snap();
    cmd(3'h1);
    err();
    wr(12'h004, 32'h0, 2'h0);
    cmd(3'h2);
    idle();
    chk(lastAddr, 12'h440);
    st(2'h0, 12'h440, 8'h00, 1'h0);
    cmd(3'h1);
    @(posedge clk);
    chk(cpuHalt, 32'h1);
    idle();
    delta(8'h41, 8'h01, 16'h3ec1);
    chk(lastAddr, 12'h47f);
    snap();
    cmd(3'h2);
    err();
    st(2'h0, 12'h85a, 8'h00, 1'h0);
    slow <= 1'h1;
    cmd(3'h2);
    loadAddr <= 12'h900;
    loadValid <= 1'h1;
    repeat (2) @(posedge clk);
    chk(loadWait, 32'h1);
    chk(cpuHalt, 32'h1);
    loadValid <= 1'h0;
    idle();
    slow <= 1'h0;
    delta(8'h01, 8'h01, 16'h0);
    chk(lastAddr, 12'h840);
  endtask

  // One command, expected request count, erases, data sum and address
  task automatic t_op(input logic [2:0] c, input logic [1:0] m, input logic [11:0] a,
                      input logic g, input logic [7:0] dn, input logic [7:0] de);
    st(m, a, 8'h11, g);
    snap();
    cmd(c);
    idle();
    delta(dn, de, 16'h0011);
    chk(lastAddr, a);
  endtask

  // Stale key window refuses the command; buffer kept for a real one
  task automatic t_key;
    st(2'h1, 12'h045, 8'h77, 1'h0);
    snap();
    wr(12'h00c, 32'h9d, 2'h0);
    rd(12'h00c);
    chk(rdv[1], 32'h1);
    repeat (4)
    begin
      @(posedge clk);
      instrRetire <= 1'h1;
      @(posedge clk);
      instrRetire <= 1'h0;
    end
    wr(12'h000, 32'h1, 2'h0);
    rd(12'h008);
    chk(rdv[1:0], 32'h0);
    cmd(3'h1);
    idle();
    delta(8'h01, 8'h00, 16'h0077);
  endtask

  // Boot lock set only from boot, active only outside it
  task automatic t_lock;
    cpuPc <= 12'h500;
    wr(12'h004, 32'h2, 2'h0);
    rd(12'h004);
    chk(rdv[1], 32'h0);
    cpuPc <= 12'h100;
    wr(12'h004, 32'h2, 2'h0);
    loadAddr <= 12'h010;
    loadValid <= 1'h1;
    repeat (2) @(posedge clk);
    chk(loadDenied, 32'h0);
    cpuPc <= 12'h500;
    repeat (2) @(posedge clk);
    chk(loadDenied, 32'h1);
    loadValid <= 1'h0;
  endtask

  // Main sequence
  initial
  begin
    t_rej(8'h00, 8'h00, 16'h0000, 12'h100, 2'h0, 12'h900);
    t_rej(8'h04, 8'h00, 16'h0004, 12'h500, 2'h0, 12'hc00);
    t_rej(8'h04, 8'h02, 16'h0204, 12'h500, 2'h1, 12'h010);
    t_rej(8'h04, 8'h08, 16'h0804, 12'ha00, 2'h1, 12'h010);
    t_rej(8'h04, 8'h08, 16'h0804, 12'h500, 2'h0, 12'h440);
    t_rej(8'h20, 8'h02, 16'h0200, 12'h100, 2'h0, 12'h300);
    t_rej(8'h03, 8'h11, 16'h0003, 12'h400, 2'h0, 12'h800);
    t_ee();
    t_refill(1'h1, 8'ha5);
    t_refill(1'h0, 8'h5a);
    t_flash();
    t_op(3'h3, 2'h1, 12'h0c3, 1'h0, 8'h02, 8'h01);
    cpuPc <= 12'ha00;
    t_op(3'h1, 2'h2, 12'h007, 1'h1, 8'h01, 8'h00);
    cpuPc <= 12'h100;
    t_key();
    t_lock();
    wr(12'h020, 32'h1, 2'h2);
    rd(12'h020);
    chk({rsp, rdv[29:0]}, 32'h80000000);
    printVerdict();
  end
endmodule
